// [shared/pss_map.svh]
// register offsets, bit positions and reset values of the status block
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH

// register indices; byte address is four times the index
`define PSS_IDX_STATUS      6'h01
`define PSS_IDX_IRQ_STATUS  6'h10
`define PSS_IDX_IRQ_MASK    6'h11

// status word
`define PSS_STATUS_RST      16'h7849
`define PSS_STATUS_W        16
`define PSS_BIT_RSVD_TOP    15
`define PSS_BIT_FAST_FULL   14
`define PSS_BIT_FAST_HALF   13
`define PSS_BIT_SLOW_FULL   12
`define PSS_BIT_SLOW_HALF   11
`define PSS_RSVD_MID_HI     10
`define PSS_RSVD_MID_LO     7
`define PSS_BIT_NO_PREAMBLE 6
`define PSS_BIT_NEG_DONE    5
`define PSS_BIT_FAR_FAULT   4
`define PSS_BIT_NEG_ABLE    3
`define PSS_BIT_LINK        2
`define PSS_BIT_BABBLE      1
`define PSS_BIT_EXTRA_REGS  0

// interrupt status and mask layout
`define PSS_IRQ_W           4
`define PSS_IRQ_FAR_FAULT   0
`define PSS_IRQ_BABBLE      1
`define PSS_IRQ_LINK_CHG    2
`define PSS_IRQ_NEG_DONE    3
`define PSS_IRQ_RST         4'h0

// bus
`define PSS_ADDR_W          8
`define PSS_DATA_W          32
`define PSS_BE_W            4
`define PSS_IDX_LSB         2
`define PSS_BE_LANE0        0
`define PSS_SYNC_STAGES     2

`endif

// [shared/pss_pkg.sv]
// types shared by the status register block
package pss_pkg;

  // raw condition levels from the transceiver core
  typedef struct packed {
    logic neg_done;
    logic link_up;
    logic far_fault;
    logic babble;
  } pss_phy_evt_s;

  // kind of access decoded each cycle from the read and write strobes
  typedef enum logic [1:0] {
    PSS_ACC_NONE  = 2'b00,
    PSS_ACC_READ  = 2'b01,
    PSS_ACC_WRITE = 2'b10
  } pss_acc_e;

  typedef logic [15:0] pss_word_t;

endpackage

// [design/pss_sync.sv]
// two-flop level synchroniser, one chain per bit
`timescale 1ns/1ps
`include "pss_map.svh"

module pss_sync
#(
  parameter int W = 4
)
(
  input  wire logic         clock_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] din_i,
  output logic      [W-1:0] dout_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // --------------------------------------------------------------
  // per-bit chains
  // --------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      always_ff @(posedge clock_i)
      begin
        if (!rst_b_i)
        begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end
        else
        begin
          meta_q[gi] <= din_i[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  assign dout_o = sync_q;

endmodule

// [design/pss_top.sv]
// transceiver status and capability register with avalon-mm slave
`timescale 1ns/1ps
`include "pss_map.svh"

module pss_top
  import pss_pkg::*;
(
  input  wire logic                    clock_i,
  input  wire logic                    rst_b_i,
  input  wire logic [`PSS_ADDR_W-1:0]  avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [`PSS_DATA_W-1:0]  avs_writedata_i,
  input  wire logic [`PSS_BE_W-1:0]    avs_byteenable_i,
  output logic      [`PSS_DATA_W-1:0]  avs_readdata_o,
  output logic                         avs_waitrequest_o,
  input  wire pss_phy_evt_s            phy_evt_i,
  output logic                         irq_o
);

  // --------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------
  pss_phy_evt_s                phy_sync;
  pss_phy_evt_s                phy_prev_q;
  logic                        far_fault_q;
  logic                        far_fault_d;
  logic                        babble_q;
  logic                        babble_d;
  pss_word_t                   status_word;
  logic                        wait_q;
  logic                        wait_d;
  logic [`PSS_DATA_W-1:0]      rdata_q;
  logic [`PSS_DATA_W-1:0]      rdata_d;
  pss_acc_e                    acc_kind;
  logic                        acc_take;
  logic [5:0]                  acc_idx;
  logic                        hit_status;
  logic                        hit_irq_sts;
  logic                        hit_irq_mask;
  logic                        clr_far_q;
  logic                        clr_far_d;
  logic                        clr_babble_q;
  logic                        clr_babble_d;
  logic                        rd_status_take;
  logic                        rd_snap;
  logic                        wr_take;
  logic [`PSS_IRQ_W-1:0]       irq_evt;
  logic [`PSS_IRQ_W-1:0]       irq_pend;
  logic [`PSS_IRQ_W-1:0]       irq_sts_q;
  logic [`PSS_IRQ_W-1:0]       irq_sts_d;
  logic [`PSS_IRQ_W-1:0]       irq_mask_q;
  logic [`PSS_IRQ_W-1:0]       irq_w1c;
  logic                        irq_q;

  // --------------------------------------------------------------
  // condition inputs
  // --------------------------------------------------------------
  // four condition levels into the clock domain
  pss_sync
  #(
    .W ($bits(pss_phy_evt_s))
  )
  u_sync
  (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .din_i   (phy_evt_i),
    .dout_o  (phy_sync)
  );

  // previous synchronised levels for edge events
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      phy_prev_q <= '0;
    end
    else
    begin
      phy_prev_q <= phy_sync;
    end
  end

  // --------------------------------------------------------------
  // bus request decode
  // --------------------------------------------------------------
  always_comb
  begin
    if (avs_read_i)
    begin
      acc_kind = PSS_ACC_READ;
    end
    else if (avs_write_i)
    begin
      acc_kind = PSS_ACC_WRITE;
    end
    else
    begin
      acc_kind = PSS_ACC_NONE;
    end
  end

  // word index from the byte address
  assign acc_idx      = avs_address_i[`PSS_ADDR_W-1:`PSS_IDX_LSB];
  assign hit_status   = (acc_idx == `PSS_IDX_STATUS);
  assign hit_irq_sts  = (acc_idx == `PSS_IDX_IRQ_STATUS);
  assign hit_irq_mask = (acc_idx == `PSS_IDX_IRQ_MASK);

  // request completes on the edge that sees waitrequest low
  assign acc_take = (acc_kind != PSS_ACC_NONE) && !wait_q;

  // a read snapshots on its first edge, a write lands on its last
  assign rd_snap = (acc_kind == PSS_ACC_READ) && wait_q;
  assign wr_take = acc_take && (acc_kind == PSS_ACC_WRITE)
                   && avs_byteenable_i[`PSS_BE_LANE0];

  // --------------------------------------------------------------
  // status word
  // --------------------------------------------------------------
  // constant bits forced here; only four bits follow the core
  always_comb
  begin
    status_word                       = `PSS_STATUS_RST;
    status_word[`PSS_BIT_RSVD_TOP]    = 1'b0;
    status_word[`PSS_RSVD_MID_HI:`PSS_RSVD_MID_LO] = '0;
    status_word[`PSS_BIT_FAST_FULL]   = 1'b1;
    status_word[`PSS_BIT_FAST_HALF]   = 1'b1;
    status_word[`PSS_BIT_SLOW_FULL]   = 1'b1;
    status_word[`PSS_BIT_SLOW_HALF]   = 1'b1;
    status_word[`PSS_BIT_NO_PREAMBLE] = 1'b1;
    status_word[`PSS_BIT_NEG_DONE]    = phy_sync.neg_done;
    status_word[`PSS_BIT_FAR_FAULT]   = far_fault_q;
    status_word[`PSS_BIT_NEG_ABLE]    = 1'b1;
    status_word[`PSS_BIT_LINK]        = phy_sync.link_up;
    status_word[`PSS_BIT_BABBLE]      = babble_q;
    status_word[`PSS_BIT_EXTRA_REGS]  = 1'b1;
  end

  // --------------------------------------------------------------
  // sticky condition flags
  // --------------------------------------------------------------
  // only bits that were returned as one are cleared, and a
  // condition still present keeps the bit set
  assign rd_status_take = acc_take && (acc_kind == PSS_ACC_READ)
                          && hit_status;

  always_comb
  begin
    far_fault_d = phy_sync.far_fault
                  | (far_fault_q & ~(rd_status_take & clr_far_q));
    babble_d    = phy_sync.babble
                  | (babble_q & ~(rd_status_take & clr_babble_q));
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      far_fault_q <= 1'b0;
    end
    else
    begin
      far_fault_q <= far_fault_d;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      babble_q <= 1'b0;
    end
    else
    begin
      babble_q <= babble_d;
    end
  end

  // --------------------------------------------------------------
  // read data and waitrequest
  // --------------------------------------------------------------
  always_comb
  begin
    rdata_d = '0;
    if (hit_status)
    begin
      rdata_d[`PSS_STATUS_W-1:0] = status_word;
    end
    else if (hit_irq_sts)
    begin
      rdata_d[`PSS_IRQ_W-1:0] = irq_sts_q;
    end
    else if (hit_irq_mask)
    begin
      rdata_d[`PSS_IRQ_W-1:0] = irq_mask_q;
    end
  end

  // one wait cycle per request, low for exactly one edge
  always_comb
  begin
    wait_d = !((acc_kind != PSS_ACC_NONE) && wait_q);
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      wait_q <= 1'b1;
    end
    else
    begin
      wait_q <= wait_d;
    end
  end

  // snapshot while waiting, held through the completing edge
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      rdata_q <= '0;
    end
    else if (rd_snap)
    begin
      rdata_q <= rdata_d;
    end
  end

  // remember which sticky bits the snapshot carried
  always_comb
  begin
    clr_far_d    = clr_far_q;
    clr_babble_d = clr_babble_q;
    if (rd_snap)
    begin
      clr_far_d    = hit_status && far_fault_q;
      clr_babble_d = hit_status && babble_q;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      clr_far_q    <= 1'b0;
      clr_babble_q <= 1'b0;
    end
    else
    begin
      clr_far_q    <= clr_far_d;
      clr_babble_q <= clr_babble_d;
    end
  end

  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;

  // --------------------------------------------------------------
  // interrupt events
  // --------------------------------------------------------------
  always_comb
  begin
    irq_evt = '0;
    irq_evt[`PSS_IRQ_FAR_FAULT] = phy_sync.far_fault
                                  & ~phy_prev_q.far_fault;
    irq_evt[`PSS_IRQ_BABBLE]    = phy_sync.babble
                                  & ~phy_prev_q.babble;
    irq_evt[`PSS_IRQ_LINK_CHG]  = phy_sync.link_up
                                  ^ phy_prev_q.link_up;
    irq_evt[`PSS_IRQ_NEG_DONE]  = phy_sync.neg_done
                                  & ~phy_prev_q.neg_done;
  end

  // write-one-to-clear, low byte lane only
  always_comb
  begin
    irq_w1c = '0;
    if (wr_take && hit_irq_sts)
    begin
      irq_w1c = avs_writedata_i[`PSS_IRQ_W-1:0];
    end
  end

  // a new event wins over a clear in the same cycle
  assign irq_sts_d = irq_evt | (irq_sts_q & ~irq_w1c);

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      irq_sts_q <= `PSS_IRQ_RST;
    end
    else
    begin
      irq_sts_q <= irq_sts_d;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      irq_mask_q <= `PSS_IRQ_RST;
    end
    else if (wr_take && hit_irq_mask)
    begin
      irq_mask_q <= avs_writedata_i[`PSS_IRQ_W-1:0];
    end
  end

  // --------------------------------------------------------------
  // interrupt output
  // --------------------------------------------------------------
  // pending means set and unmasked; output lags it by one edge
  assign irq_pend = irq_sts_q & irq_mask_q;

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |irq_pend;
    end
  end

  assign irq_o = irq_q;

endmodule

// [tb/pss_checker.sv]
// port assertions for the status register block
`timescale 1ns/1ps
`include "pss_map.svh"

module pss_checker
  import pss_pkg::*;
(
  input  wire logic                   clock_i,
  input  wire logic                   rst_b_i,
  input  wire logic [`PSS_ADDR_W-1:0] avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [`PSS_DATA_W-1:0] avs_writedata_i,
  input  wire logic [`PSS_BE_W-1:0]   avs_byteenable_i,
  input  wire logic [`PSS_DATA_W-1:0] avs_readdata_o,
  input  wire logic                   avs_waitrequest_o,
  input  wire pss_phy_evt_s           phy_evt_i,
  input  wire logic                   irq_o
);
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  logic         rdone;
  logic         sdone;
  logic [2:0]   same_q;
  pss_phy_evt_s evt_q;
  assign rdone = avs_read_i && !avs_waitrequest_o;
  assign sdone = rdone && avs_address_i[7:2] == `PSS_IDX_STATUS;

  // cycles the condition inputs have been steady, saturating
  always_ff @(posedge clock_i)
  begin
    evt_q <= phy_evt_i;
    if (!rst_b_i || evt_q != phy_evt_i)
      same_q <= 3'h0;
    else if (same_q != 3'h7)
      same_q <= same_q + 3'h1;
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  a_reset_values: assert property (disable iff (1'b0) !rst_b_i |=>
    avs_waitrequest_o && !irq_o && avs_readdata_o == 32'h0)
    else $error("outputs not at reset values");
  a_wait_one_cycle: assert property ((avs_read_i || avs_write_i)
    && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("waitrequest not low for one cycle");
  a_idle_wait_high: assert property (!(avs_read_i || avs_write_i)
    |=> avs_waitrequest_o)
    else $error("waitrequest low without request");
  a_fixed_status_bits: assert property (
    sdone |-> (avs_readdata_o & 32'hffff_ffc9) == 32'h0000_7849)
    else $error("fixed status bits wrong");
  a_level_status_bits: assert property (
    sdone && same_q == 3'h7 |->
    avs_readdata_o[5] == phy_evt_i.neg_done
    && avs_readdata_o[2] == phy_evt_i.link_up
    && (!phy_evt_i.far_fault || avs_readdata_o[4])
    && (!phy_evt_i.babble || avs_readdata_o[1]))
    else $error("condition status bits wrong");
  a_sticky_read_clear: assert property ((sdone && same_q == 3'h7
    && !phy_evt_i.far_fault && !phy_evt_i.babble)
    ##[1:8] (sdone && same_q == 3'h7)
    |-> avs_readdata_o[4] == 1'b0 && avs_readdata_o[1] == 1'b0)
    else $error("sticky bits not cleared by read");
  a_read_data_hold: assert property (!avs_waitrequest_o
    |=> $stable(avs_readdata_o))
    else $error("read data changed after completion");
  a_unmapped_zero: assert property (rdone
    && !(avs_address_i[7:2] inside {`PSS_IDX_STATUS, `PSS_IDX_IRQ_STATUS,
    `PSS_IDX_IRQ_MASK}) |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
endmodule

bind pss_top pss_checker u_chk
(
  .clock_i           (clock_i),
  .rst_b_i           (rst_b_i),
  .avs_address_i     (avs_address_i),
  .avs_read_i        (avs_read_i),
  .avs_write_i       (avs_write_i),
  .avs_writedata_i   (avs_writedata_i),
  .avs_byteenable_i  (avs_byteenable_i),
  .avs_readdata_o    (avs_readdata_o),
  .avs_waitrequest_o (avs_waitrequest_o),
  .phy_evt_i         (phy_evt_i),
  .irq_o             (irq_o)
);

// [tb/pss_host.sv]
// avalon-mm master model standing in for the management controller
`timescale 1ns/1ps

module pss_host
(
  input  wire logic        clock_i,
  input  wire logic        waitrequest_i,
  input  wire logic [31:0] readdata_i,
  output logic      [7:0]  address_o,
  output logic             read_o,
  output logic             write_o,
  output logic      [31:0] writedata_o,
  output logic      [3:0]  byteenable_o
);
  initial
  begin
    address_o = 8'h00;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h0;
    byteenable_o = 4'h0;
  end

  // one transfer, held until waitrequest is seen low at an edge
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] b,
                      output logic [31:0] q);
    @(posedge clock_i);
    address_o <= a;
    writedata_o <= d;
    byteenable_o <= b;
    read_o <= !wr;
    write_o <= wr;
    do
    begin
      @(posedge clock_i);
    end
    while (waitrequest_i !== 1'b0);
    q = readdata_i;
    read_o <= 1'b0;
    write_o <= 1'b0;
  endtask
endmodule

// [tb/phy_status_register_test.sv]
// self-checking bench for the status register block
`timescale 1ns/1ps

module phy_status_register_test
  import pss_pkg::*;
;
  logic         clock_i = 1'b0;
  logic         rst_b_i = 1'b0;
  pss_phy_evt_s evt     = '0;
  logic [7:0]   address;
  logic         read;
  logic         write;
  logic [31:0]  wdata;
  logic [3:0]   be;
  logic [31:0]  rdata;
  logic         waitreq;
  logic         irq;
  logic [31:0]  q;
  int           mismatches = 0;
  int           compares   = 0;
  // condition inputs beside the status word they should give
  logic [19:0]  rows [6] = '{20'h07849, 20'h1784b, 20'h27859,
                             20'h4784d, 20'h87869, 20'hf787f};

  always #50 clock_i = ~clock_i;

  pss_host u_host (.clock_i(clock_i), .waitrequest_i(waitreq),
    .readdata_i(rdata), .address_o(address), .read_o(read),
    .write_o(write), .writedata_o(wdata), .byteenable_o(be));

  pss_top u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .avs_address_i(address), .avs_read_i(read), .avs_write_i(write),
    .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .phy_evt_i(evt), .irq_o(irq));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_sim;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task rd(input logic [7:0] a);
    u_host.xfer(1'b0, a, 32'h0, 4'hf, q);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, 4'hf, q);
  endtask

  task set_evt(input logic [3:0] v, input int n);
    @(posedge clock_i);
    evt <= v;
    repeat (n) @(posedge clock_i);
  endtask

  initial
  begin
    repeat (20000) @(posedge clock_i);
    mismatches++;
    end_sim();
  end

  initial
  begin
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rd(8'h04);
    check(q, 32'h7849);
    wr(8'h04, 32'h0);
    rd(8'h04);
    check(q, 32'h7849);
    rd(8'h08);
    check(q, 32'h0);
    // --------------------------------------------------------------
    // steady conditions, second of two back-to-back reads
    // --------------------------------------------------------------
    foreach (rows[i])
    begin
      set_evt(rows[i][19:16], 8);
      rd(8'h04);
      rd(8'h04);
      check(q, {16'h0, rows[i][15:0]});
    end
    // --------------------------------------------------------------
    // sticky bits survive the condition, then clear on read
    // --------------------------------------------------------------
    set_evt(4'h0, 8);
    rd(8'h04);
    check(q, 32'h785b);
    rd(8'h04);
    check(q, 32'h7849);
    // --------------------------------------------------------------
    // interrupt raise, mask and clear
    // --------------------------------------------------------------
    wr(8'h40, 32'hf);
    wr(8'h44, 32'h1);
    check({31'h0, irq}, 32'h0);
    set_evt(4'h2, 6);
    check({31'h0, irq}, 32'h1);
    set_evt(4'h0, 6);
    check({31'h0, irq}, 32'h1);
    wr(8'h40, 32'h1);
    repeat (3) @(posedge clock_i);
    check({31'h0, irq}, 32'h0);
    wr(8'h44, 32'h0);
    set_evt(4'h1, 6);
    check({31'h0, irq}, 32'h0);
    rd(8'h40);
    check(q, 32'h2);
    rd(8'h44);
    check(q, 32'h0);
    u_host.xfer(1'b1, 8'h44, 32'hf, 4'he, q);
    rd(8'h44);
    check(q, 32'h0);
    // --------------------------------------------------------------
    // reset in mid-run drops the held fault and the interrupt
    // --------------------------------------------------------------
    set_evt(4'h2, 6);
    set_evt(4'h0, 4);
    wr(8'h44, 32'h2);
    repeat (2) @(posedge clock_i);
    check({31'h0, irq}, 32'h1);
    rst_b_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rd(8'h04);
    check(q, 32'h7849);
    check({31'h0, irq}, 32'h0);
    end_sim();
  end
endmodule
